// file: design/smcr_pulse.v
// Self-clearing trigger that stretches a write strobe into a pulse.
`timescale 1ns/1ps
module smcr_pulse (
  // Clock and reset.
  input  wire       i_clk,
  input  wire       i_sys_rst,
  // Launch strobe.
  input  wire       i_fire,
  // Pulse output.
  output reg        o_pulse
);
`include "smcr_consts.vh"

  reg  [3:0] cnt_q;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q   <= 4'h0;
      o_pulse <= 1'b0;
    end else if (i_fire) begin
      cnt_q   <= `SMCR_PULSE_CYC - 4'h1;
      o_pulse <= 1'b1;
    end else if (cnt_q != 4'h0) begin
      cnt_q   <= cnt_q - 4'h1;
      o_pulse <= 1'b1;
    end else begin
      o_pulse <= 1'b0;
    end
  end

endmodule // smcr_pulse

// file: design/smcr_regs.v
// Main control register bank: identity, reset control, general config.
//
// Function
// - Identity bits 7:1 hold the bus target identifier and always read back the one in use.
// - With the override clear the identifier is read-only and shows the strapped value.
// - With the override set the identifier is writable and the written value is used.
// - Writing 1 to reset bit 2 launches a ROM reload and the bit clears itself.
// - Writing 1 to reset bit 1 resets all logic including registers and clears itself.
// - Writing 1 to reset bit 0 resets logic but keeps registers and clears itself.
// - Config bit 6 selects continuous clock lane, 0 non-continuous, reset 0.
// - Config bits 5:4 select 1, 2 or 4 data lanes and reset to 0x3.
// - Config bit 0 takes the bus voltage strap at start-up and stays writable.
`timescale 1ns/1ps
module smcr_regs (
  // Clock and reset.
  input  wire       i_clk,
  input  wire       i_sys_rst,
  // Register access port.
  input  wire       i_wr_en,
  input  wire       i_rd_en,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata,
  // Strap inputs.
  input  wire [6:0] i_address_strap_pin,
  input  wire       i_vsel_strap,
  // Configuration outputs.
  output reg  [6:0] o_bus_target_id,
  output reg        o_clock_lane_continuous,
  output reg  [1:0] o_lane_sel,
  output reg        o_tx_checksum_generator_on,
  output reg        o_bus_1v8_sel,
  // Reset and reload pulses.
  output reg        o_rom_reload,
  output reg        o_logic_reset
);
`include "smcr_consts.vh"

  // Strap synchronisers: first stage feeds only the second.
  reg  [6:0] id_s1_q;
  reg  [6:0] id_s2_q;
  reg        vs_s1_q;
  reg        vs_s2_q;
  // Start-up capture: one cycle after release of the second stage.
  reg  [1:0] boot_q;
  reg  [6:0] strap_id_q;

  // Register storage.
  reg        ovr_q;
  reg  [6:0] wr_id_q;
  reg  [4:0] rst_rsvd_q;
  reg        cfg_rsvd7_q;
  reg        cont_q;
  reg  [1:0] lane_q;
  reg  [1:0] cfg_rsvd_q;
  reg        crc_q;
  reg        vsel_q;

  // Full-reset request holds registers in reset for a pulse.
  wire       full_pulse;
  wire       keep_pulse;
  wire       rom_pulse;
  wire       reg_rst = i_sys_rst | full_pulse;

  wire       wr_rst = i_wr_en & (i_addr == `SMCR_ADDR_RESET);
  wire       wr_id  = i_wr_en & (i_addr == `SMCR_ADDR_IDENT);
  wire       wr_cfg = i_wr_en & (i_addr == `SMCR_ADDR_GENCFG);

  wire [6:0] id_now = ovr_q ? wr_id_q : strap_id_q;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      id_s1_q <= 7'h00;
      id_s2_q <= 7'h00;
      vs_s1_q <= 1'b0;
      vs_s2_q <= 1'b0;
    end else begin
      id_s1_q <= i_address_strap_pin;
      id_s2_q <= id_s1_q;
      vs_s1_q <= i_vsel_strap;
      vs_s2_q <= vs_s1_q;
    end
  end

  // Strapped identifier is caught once after reset release.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      boot_q     <= 2'h0;
      strap_id_q <= `SMCR_ID_RST;
    end else begin
      if (boot_q != `SMCR_BOOT_END) begin
        boot_q <= boot_q + 2'h1;
      end
      if (boot_q == `SMCR_BOOT_CAP) begin
        strap_id_q <= id_s2_q;
      end
    end
  end

  // Register file, cleared by power-on reset and by the full logic reset.
  always @(posedge i_clk or posedge reg_rst) begin
    if (reg_rst) begin
      ovr_q       <= 1'b0;
      wr_id_q     <= `SMCR_ID_RST;
      rst_rsvd_q  <= `SMCR_RST_RSVD_RST;
      cfg_rsvd7_q <= 1'b0;
      cont_q      <= `SMCR_CONT_RST;
      lane_q      <= `SMCR_LANE_RST;
      cfg_rsvd_q  <= `SMCR_CFG_RSVD_RST;
      crc_q       <= `SMCR_CRC_RST;
      vsel_q      <= `SMCR_VSEL_RST;
    end else begin
      if (boot_q == `SMCR_BOOT_CAP) begin
        vsel_q <= vs_s2_q;
      end else if (wr_cfg) begin
        vsel_q <= i_wdata[`SMCR_CFG_VSEL_BIT];
      end
      if (wr_id) begin
        ovr_q <= i_wdata[`SMCR_ID_OVR_BIT];
        if (ovr_q) begin
          wr_id_q <= i_wdata[`SMCR_ID_HI:`SMCR_ID_LO];
        end else begin
          wr_id_q <= id_now;
        end
      end
      if (wr_rst) begin
        rst_rsvd_q <= i_wdata[`SMCR_RST_RSVD_HI:`SMCR_RST_RSVD_LO];
      end
      if (wr_cfg) begin
        cfg_rsvd7_q <= i_wdata[`SMCR_CFG_RSVD7_BIT];
        cont_q      <= i_wdata[`SMCR_CFG_CONT_BIT];
        lane_q      <= i_wdata[`SMCR_CFG_LANE_HI:`SMCR_CFG_LANE_LO];
        cfg_rsvd_q  <= i_wdata[`SMCR_CFG_RSVD_HI:`SMCR_CFG_RSVD_LO];
        crc_q       <= i_wdata[`SMCR_CFG_CRC_BIT];
      end
    end
  end

  // Trigger bits are never stored; a 1 launches a pulse, a 0 is ignored.
  smcr_pulse u_rom (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_fire    (wr_rst & i_wdata[`SMCR_RST_ROM_BIT]),
    .o_pulse   (rom_pulse)
  );

  smcr_pulse u_full (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_fire    (wr_rst & i_wdata[`SMCR_RST_FULL_BIT]),
    .o_pulse   (full_pulse)
  );

  smcr_pulse u_keep (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_fire    (wr_rst & i_wdata[`SMCR_RST_KEEP_BIT]),
    .o_pulse   (keep_pulse)
  );

  // Outputs and read data, all registered.
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata                    <= 8'h00;
      o_bus_target_id            <= `SMCR_ID_RST;
      o_clock_lane_continuous    <= `SMCR_CONT_RST;
      o_lane_sel                 <= `SMCR_LANE_RST;
      o_tx_checksum_generator_on <= `SMCR_CRC_RST;
      o_bus_1v8_sel              <= `SMCR_VSEL_RST;
      o_rom_reload               <= 1'b0;
      o_logic_reset              <= 1'b0;
    end else begin
      o_bus_target_id            <= id_now;
      o_clock_lane_continuous    <= cont_q;
      o_lane_sel                 <= lane_q;
      o_tx_checksum_generator_on <= crc_q;
      o_bus_1v8_sel              <= vsel_q;
      o_rom_reload               <= rom_pulse;
      o_logic_reset              <= keep_pulse | full_pulse;
      if (i_rd_en) begin
        case (i_addr)
          `SMCR_ADDR_IDENT: begin
            o_rdata <= {id_now, ovr_q};
          end
          `SMCR_ADDR_RESET: begin
            o_rdata <= {rst_rsvd_q, 3'h0};
          end
          `SMCR_ADDR_GENCFG: begin
            o_rdata <= {cfg_rsvd7_q, cont_q, lane_q, cfg_rsvd_q, crc_q,
                        vsel_q};
          end
          default: begin
            o_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

endmodule // smcr_regs

// file: pkg/smcr_consts.vh
// Constants for the serializer main control register bank.
`ifndef SMCR_CONSTS_VH
`define SMCR_CONSTS_VH

// Register offsets.
`define SMCR_ADDR_IDENT      8'h00
`define SMCR_ADDR_RESET      8'h01
`define SMCR_ADDR_GENCFG     8'h02

// Identity register fields.
`define SMCR_ID_OVR_BIT      0
`define SMCR_ID_HI           7
`define SMCR_ID_LO           1

// Reset register fields.
`define SMCR_RST_ROM_BIT     2
`define SMCR_RST_FULL_BIT    1
`define SMCR_RST_KEEP_BIT    0
`define SMCR_RST_RSVD_HI     7
`define SMCR_RST_RSVD_LO     3

// General configuration fields.
`define SMCR_CFG_RSVD7_BIT   7
`define SMCR_CFG_CONT_BIT    6
`define SMCR_CFG_LANE_HI     5
`define SMCR_CFG_LANE_LO     4
`define SMCR_CFG_RSVD_HI     3
`define SMCR_CFG_RSVD_LO     2
`define SMCR_CFG_CRC_BIT     1
`define SMCR_CFG_VSEL_BIT    0

// Reset values.
`define SMCR_RST_RSVD_RST    5'h00
`define SMCR_LANE_RST        2'h3
`define SMCR_CFG_RSVD_RST    2'h0
`define SMCR_ID_RST          7'h00
`define SMCR_CRC_RST         1'b1
`define SMCR_CONT_RST        1'b0
`define SMCR_VSEL_RST        1'b0

// Start-up counter: straps are caught at the capture count.
`define SMCR_BOOT_CAP        2'h2
`define SMCR_BOOT_END        2'h3

// Width of the reset pulses launched by the trigger bits.
`define SMCR_PULSE_CYC       4'h4

`endif

// file: test/smcr_host.sv
// Register port host issuing single-cycle accesses.
`timescale 1ns/1ps
module smcr_host (
  input  wire       i_clk,
  output reg        o_wr_en,
  output reg        o_rd_en,
  output reg  [7:0] o_addr,
  output reg  [7:0] o_wdata
);
  initial {o_wr_en, o_rd_en, o_addr, o_wdata} = 18'h00000;
  // Stands for the back channel, the only source of voltage writes.
  task acc(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      o_wr_en <= w;
      o_rd_en <= !w;
      o_addr  <= a;
      o_wdata <= d;
      @(posedge i_clk);
      {o_wr_en, o_rd_en} <= 2'b00;
      o_addr  <= ~a;
      o_wdata <= ~d;
    end
  endtask
endmodule // smcr_host

// file: test/smcr_regs_checker.sv
// Port assertions for the main control register bank.
`timescale 1ns/1ps
module smcr_regs_checker (
  // Watched ports.
  input wire       i_clk,
  input wire       i_sys_rst,
  input wire       i_wr_en,
  input wire       i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire       o_clock_lane_continuous,
  input wire [1:0] o_lane_sel,
  input wire       o_tx_checksum_generator_on,
  input wire       o_bus_1v8_sel,
  input wire       o_rom_reload,
  input wire       o_logic_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_rom_len: assert property ($rose(o_rom_reload) |->
    o_rom_reload[*4] ##1 !o_rom_reload) else $error("rom pulse length");
  chk_rst_len: assert property ($rose(o_logic_reset) |->
    o_logic_reset[*4] ##1 !o_logic_reset) else $error("reset pulse length");
  chk_rom_cause: assert property ($rose(o_rom_reload) |->
    $past(i_wr_en && i_addr == 8'h01 && i_wdata[2], 2))
    else $error("rom pulse without trigger");
  chk_rst_cause: assert property ($rose(o_logic_reset) |->
    $past(i_wr_en && i_addr == 8'h01 && (i_wdata[1] | i_wdata[0]), 2))
    else $error("reset pulse without trigger");
  chk_unmapped_read: assert property (i_rd_en && i_addr > 8'h02 |=>
    o_rdata == 8'h00) else $error("unmapped read not zero");
  chk_trig_read: assert property (i_rd_en && i_addr == 8'h01 |=>
    o_rdata[2:0] == 3'h0) else $error("trigger bit reads one");
  chk_lane_write: assert property (i_wr_en && i_addr == 8'h02 |->
    ##2 {o_clock_lane_continuous, o_lane_sel} == $past(i_wdata[6:4], 2))
    else $error("lane fields not written");
  chk_low_write: assert property (i_wr_en && i_addr == 8'h02 |->
    ##2 {o_tx_checksum_generator_on, o_bus_1v8_sel} == $past(i_wdata[1:0], 2))
    else $error("low config bits not written");
endmodule // smcr_regs_checker

// file: test/smcr_regs_test.sv
// Self-checking bench for the main control register bank.
`timescale 1ns/1ps
module smcr_regs_test;
  reg         i_clk = 1'b0;
  reg         i_sys_rst = 1'b1;
  reg  [6:0]  i_address_strap_pin;
  reg         i_vsel_strap;
  reg  [7:0]  d;
  reg         rd_d = 1'b0;
  wire        i_wr_en, i_rd_en, o_clock_lane_continuous;
  wire        o_tx_checksum_generator_on, o_bus_1v8_sel;
  wire        o_rom_reload, o_logic_reset;
  wire [7:0]  i_addr, i_wdata, o_rdata;
  wire [6:0]  o_bus_target_id;
  wire [1:0]  o_lane_sel;
  integer     err_count = 0;
  integer     checked = 0;
  integer     i;
  logic [7:0] exp_q[$];
  initial forever #5 i_clk = ~i_clk;
  smcr_host host_u (.i_clk, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_addr(i_addr), .o_wdata(i_wdata));
  smcr_regs dut_u (.i_clk, .i_sys_rst, .i_wr_en, .i_rd_en, .i_addr,
    .i_wdata, .o_rdata, .i_address_strap_pin, .i_vsel_strap,
    .o_bus_target_id, .o_clock_lane_continuous, .o_lane_sel,
    .o_tx_checksum_generator_on, .o_bus_1v8_sel, .o_rom_reload,
    .o_logic_reset);
  task chk(input [7:0] s, input [7:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      host_u.acc(1'b0, a, 8'h00);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge i_clk) rd_d <= i_rd_en;
  always @(negedge i_clk) if (rd_d) chk(o_rdata, exp_q.pop_front());
  initial begin
    d = $urandom(32'h8902d002);
    i_address_strap_pin = $urandom;
    i_vsel_strap = $urandom;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    rd(8'h00, {i_address_strap_pin, 1'b0});
    rd(8'h01, 8'h00);
    rd(8'h02, {6'h0C, 1'b1, i_vsel_strap});
    host_u.acc(1'b1, 8'h00, 8'hAA);
    rd(8'h00, {i_address_strap_pin, 1'b0});
    d = $urandom | 8'h01;
    host_u.acc(1'b1, 8'h00, 8'h01);
    host_u.acc(1'b1, 8'h00, d);
    rd(8'h00, d);
    chk({1'b0, o_bus_target_id}, {1'b0, d[7:1]});
    host_u.acc(1'b1, 8'h00, 8'h00);
    rd(8'h00, {i_address_strap_pin, 1'b0});
    for (i = 0; i < 3; i = i + 1) begin
      d = ($urandom & 8'hCF) | ((i == 2) ? 8'h30 : i << 4);
      host_u.acc(1'b1, 8'h02, d);
      rd(8'h02, d);
    end
    d = 8'h03 + $urandom % 8'hFC;
    host_u.acc(1'b1, d, 8'h5A);
    rd(d, 8'h00);
    host_u.acc(1'b1, 8'h01, 8'hF8);
    rd(8'h01, 8'hF8);
    chk({6'h00, o_rom_reload, o_logic_reset}, 8'h00);
    host_u.acc(1'b1, 8'h01, 8'h04);
    @(posedge i_clk) #1;
    chk({6'h00, o_rom_reload, o_logic_reset}, 8'h02);
    rd(8'h01, 8'h00);
    host_u.acc(1'b1, 8'h02, 8'h4D);
    host_u.acc(1'b1, 8'h01, 8'h01);
    @(posedge i_clk) #1;
    chk({6'h00, o_rom_reload, o_logic_reset}, 8'h01);
    repeat (6) @(posedge i_clk);
    rd(8'h02, 8'h4D);
    host_u.acc(1'b1, 8'h01, 8'h02);
    @(posedge i_clk) #1;
    chk({6'h00, o_rom_reload, o_logic_reset}, 8'h01);
    repeat (6) @(posedge i_clk);
    rd(8'h02, 8'h32);
    repeat (3) @(posedge i_clk);
    test_done;
  end
  initial begin
    #20000;
    err_count = err_count + 1;
    test_done;
  end
endmodule // smcr_regs_test

bind smcr_regs smcr_regs_checker chk_u (
  .i_clk                      (i_clk),
  .i_sys_rst                  (i_sys_rst),
  .i_wr_en                    (i_wr_en),
  .i_rd_en                    (i_rd_en),
  .i_addr                     (i_addr),
  .i_wdata                    (i_wdata),
  .o_rdata                    (o_rdata),
  .o_clock_lane_continuous    (o_clock_lane_continuous),
  .o_lane_sel                 (o_lane_sel),
  .o_tx_checksum_generator_on (o_tx_checksum_generator_on),
  .o_bus_1v8_sel              (o_bus_1v8_sel),
  .o_rom_reload               (o_rom_reload),
  .o_logic_reset              (o_logic_reset)
);
